// ### pkg/adc_seq_consts.svh
// Timing counts and reset values for the conversion sequencer.
// Assumes the sequencer clock is the device oscillator at 125 MHz.
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// Clock period, ns
`define CLK_PERIOD_NS     8
// Least per-bit period for valid bits, ns
`define TAD_MIN_NS        1600
// Typical internal RC per-bit period, ns
`define RC_TAD_NS         4000
// Least time rounds up to whole cycles
`define TAD_MIN_CYCLES    ((`TAD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Typical time, rounded down
`define RC_TAD_CYCLES     (`RC_TAD_NS / `CLK_PERIOD_NS)
// Oscillator-derived per-bit periods, in clocks
`define TAD_OSC_DIV2      2
`define TAD_OSC_DIV8      8
`define TAD_OSC_DIV32     32
// Clock select codes
`define SEL_DIV2          2'h0
`define SEL_DIV8          2'h1
`define SEL_DIV32         2'h2
`define SEL_RC            2'h3
// Phase lengths counted in half periods
`define CONV_HALVES       19
`define HOLD_HALVES       5'h03
`define DEAD_HALVES       5'h04
`define RESULT_BITS       8
`define RESULT_RESET      8'h00

`endif

// ### pkg/adc_seq_pkg.sv
// Types and shared decode for the conversion sequencer.
// Assumes the constants header is on the include path.
`include "adc_seq_consts.svh"

package adc_seq_pkg;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,  // Converter switched off
    ST_ACQUIRE = 5'h02,  // Holding capacitor on the channel
    ST_HOLD    = 5'h04,  // Disconnect before first decision
    ST_CONVERT = 5'h08,  // One decision per period
    ST_DEAD    = 5'h10   // Settle after completion or abort
  } seq_state_t;

  // Software-side control bits
  typedef struct packed {
    logic       converterOn;
    logic [1:0] convClockSelect;
    logic [2:0] inputChannelSelect;
  } conv_ctrl_t;

  // Software write strobes
  typedef struct packed {
    logic       goWrite;     // Strobe for the go/done bit
    logic       goValue;     // Value written
    logic       resultWrite; // Strobe for the result register
    logic [7:0] resultData;
    logic       flagClear;   // Clears the done flag
  } sw_write_t;

  // Per-bit period in clocks for a clock select
  function automatic logic [9:0] tad_cycles(input logic [1:0] sel);
    logic [9:0] n;
    n = 10'(`RC_TAD_CYCLES);
    case (sel)
      `SEL_DIV2:  n = 10'(`TAD_OSC_DIV2);
      `SEL_DIV8:  n = 10'(`TAD_OSC_DIV8);
      `SEL_DIV32: n = 10'(`TAD_OSC_DIV32);
      default:    n = 10'(`RC_TAD_CYCLES);
    endcase
    return n;
  endfunction

endpackage

// ### rtl/bit_period_gen.sv
// Free-running divider giving a half-period tick of the per-bit clock.
// Assumes clk is the device oscillator; the RC source is modelled from clk.
`timescale 1ns/1ps

module bit_period_gen
  import adc_seq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [1:0] convClockSelect,
  output      logic       halfTick
);

  logic [8:0] divCount;   // Free-running half-period counter
  wire  [9:0] tadLen;     // Current per-bit period in clocks
  wire  [8:0] halfLimit;  // Last count of a half period
  wire        wrap;       // Half period elapsed

  // divide by 2, 8, 32 or RC figure
  assign tadLen    = tad_cycles(convClockSelect);
  assign halfLimit = tadLen[9:1] - 9'h001;
  // Switching select mid-way: a larger count wraps at once
  assign wrap      = (divCount >= halfLimit);

  ////////////////////////////////////////////////////////////////////
  // free-running divider
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCount <= 9'h000;
      halfTick <= 1'b0;
    end else begin
      divCount <= wrap ? 9'h000 : divCount + 9'h001;
      halfTick <= wrap;
    end
  end

endmodule

// ### rtl/adc_conversion_sequencer.sv
// Conversion sequencer for an 8-bit successive-approximation converter.
// Assumes an external comparator and DAC; software bits arrive as ports.
`timescale 1ns/1ps

module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire conv_ctrl_t ctrl,
  input  wire sw_write_t  swWrite,
  input  wire logic       compIn,
  input  wire logic [5:0] portPins,
  input  wire logic [5:0] analogPinMask,
  output      logic       goBusy,
  output      logic [7:0] convResultReg,
  output      logic       convDoneFlag,
  output      logic [7:0] resultBitInvalid,
  output      logic       sampleSwitch,
  output      logic [2:0] channelMux,
  output      logic [7:0] dacCode,
  output      logic [5:0] portReadData
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  seq_state_t state;            // Sequencer state
  seq_state_t next_state;       // Next state
  logic [4:0] halfCount;        // Half periods spent in a phase
  logic [2:0] bitIndex;         // Bit under decision
  logic       violated;         // Sticky short-period mark
  logic       onQ;              // Converter enable from earlier write
  logic       compMeta;         // Comparator sync stage one
  logic       compSync;         // Comparator sync stage two
  logic [5:0] pinMeta;          // Port sync stage one
  logic [5:0] pinSync;          // Port sync stage two
  wire        halfTick;         // Half per-bit period pulse
  wire        startReq;         // Software start
  wire        abortReq;         // Software abort
  wire        busyPhase;        // Hold or convert under way
  wire        decide;           // A decision this cycle
  wire        lastBit;          // Final decision
  wire        complete;         // Conversion done this cycle
  wire        shortTad;         // Period below the least
  wire        phaseDone;        // Hold or dead phase over
  wire [7:0]  trialMask;        // One-hot bit under trial
  wire [7:0]  keptCode;         // Code once this bit is decided

  bit_period_gen u_period (
    .clk             (clk),
    .resetn          (resetn),
    .convClockSelect (ctrl.convClockSelect),
    .halfTick        (halfTick)
  );

  ////////////////////////////////////////////////////////////////////
  // Input synchronisers: comparator and port pins are asynchronous
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      compMeta <= 1'b0;
      compSync <= 1'b0;
      pinMeta  <= 6'h00;
      pinSync  <= 6'h00;
    end else begin
      compMeta <= compIn;
      compSync <= compMeta;
      pinMeta  <= portPins;
      pinSync  <= pinMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Decode

  // enable must come from an earlier write
  assign startReq  = swWrite.goWrite & swWrite.goValue & onQ;
  // clear of go during a conversion aborts
  assign abortReq  = swWrite.goWrite & ~swWrite.goValue & busyPhase;
  assign busyPhase = (state == ST_HOLD) | (state == ST_CONVERT);
  // one decision per full period, odd half ticks
  assign decide    = (state == ST_CONVERT) & halfTick & halfCount[0];
  assign lastBit   = (bitIndex == 3'h0);
  // 3 hold halves plus 16 convert halves is 9.5 periods
  assign complete  = decide & lastBit & ~abortReq;
  assign phaseDone = halfTick & (halfCount == ((state == ST_HOLD) ? `HOLD_HALVES - 5'h01
                                                                 : `DEAD_HALVES - 5'h01));
  // compare the live period with the least
  assign shortTad  = (tad_cycles(ctrl.convClockSelect) < 10'(`TAD_MIN_CYCLES));
  assign trialMask = 8'h01 << bitIndex;
  // keep the trial bit when input is at or above the DAC
  assign keptCode  = compSync ? dacCode : (dacCode & ~trialMask);

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_OFF: begin
        // Acquisition begins once enabled
        if (onQ) begin
          next_state = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        // acquisition is software timed, same for any resolution
        if (startReq) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (abortReq) begin
          next_state = ST_DEAD;
        end else if (phaseDone) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (abortReq || complete) begin
          next_state = ST_DEAD;
        end
      end
      ST_DEAD: begin
        if (phaseDone) begin
          next_state = ST_ACQUIRE;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    // Switching off wins over everything
    if (!onQ) begin
      next_state = ST_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State, phase counter and enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_OFF;
      halfCount <= 5'h00;
      onQ       <= 1'b0;
    end else begin
      state     <= next_state;
      onQ       <= ctrl.converterOn;
      // Count restarts at each phase change
      if (next_state != state) begin
        halfCount <= 5'h00;
      end else if (halfTick) begin
        halfCount <= halfCount + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Successive approximation, most significant bit first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitIndex <= 3'h7;
      dacCode  <= 8'h00;
    end else if (startReq && state == ST_ACQUIRE) begin
      bitIndex <= 3'h7;
      dacCode  <= 8'h80;
    end else if (decide) begin
      // settle this bit, put the next one on trial
      bitIndex <= bitIndex - 3'h1;
      dacCode  <= keptCode | (trialMask >> 1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bits decided on too short a period, and all after them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      violated         <= 1'b0;
      resultBitInvalid <= 8'h00;
    end else if (startReq && state == ST_ACQUIRE) begin
      violated         <= 1'b0;
      resultBitInvalid <= 8'h00;
    end else if (decide) begin
      // once violated, every later bit stays invalid
      violated         <= violated | shortTad;
      resultBitInvalid <= resultBitInvalid | ((violated | shortTad) ? trialMask : 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Result register, go bit and done flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      convResultReg <= `RESULT_RESET;
      goBusy        <= 1'b0;
      convDoneFlag  <= 1'b0;
    end else begin
      // completion loads the result; beats a software write
      if (complete) begin
        convResultReg <= keptCode;
      end else if (swWrite.resultWrite) begin
        // an abort never touches the result
        convResultReg <= swWrite.resultData;
      end
      // go reads one for the whole conversion
      if (complete || abortReq || !onQ) begin
        goBusy <= 1'b0;
      end else if (startReq && state == ST_ACQUIRE) begin
        goBusy <= 1'b1;
      end
      // completion sets the flag; set beats clear
      convDoneFlag <= complete | (convDoneFlag & ~swWrite.flagClear);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sampling switch, channel mux and port read-back
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sampleSwitch <= 1'b0;
      channelMux   <= 3'h0;
      portReadData <= 6'h00;
    end else begin
      // capacitor off the channel outside acquisition
      sampleSwitch <= (next_state == ST_ACQUIRE);
      // channel chosen without regard to pin direction
      channelMux   <= ctrl.inputChannelSelect;
      portReadData <= pinSync & ~analogPinMask;
    end
  end

endmodule

// ### test/adc_seq_checker.sv
// Port checker for the conversion sequencer.
// Assumes one clock domain and an active-low reset.
`timescale 1ns/1ps

module adc_seq_checker
  import adc_seq_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire conv_ctrl_t ctrl,
  input wire sw_write_t  swWrite,
  input wire logic       goBusy,
  input wire logic [7:0] convResultReg,
  input wire logic       convDoneFlag,
  input wire logic       sampleSwitch,
  input wire logic [5:0] analogPinMask,
  input wire logic [5:0] portReadData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Decoded go writes
  wire goSet = swWrite.goWrite && swWrite.goValue;
  wire goClr = swWrite.goWrite && !swWrite.goValue;

  ////////////////////////////////////////////////////////////////
  a_go_start: assert property (goSet && ctrl.converterOn && $past(ctrl.converterOn)
    && sampleSwitch |=> goBusy)
    else $error("go write not taken");
  a_abort_now: assert property (goClr && goBusy |=> !goBusy)
    else $error("abort not immediate");
  a_abort_keep: assert property (goClr && goBusy && !swWrite.resultWrite
    |=> $stable(convResultReg))
    else $error("abort changed result");
  a_busy_disconnect: assert property (goBusy |-> !sampleSwitch)
    else $error("switch closed while busy");
  a_dead_gap: assert property ($fell(goBusy) |-> !sampleSwitch [*3])
    else $error("acquire too soon");
  a_done_ends: assert property ($rose(convDoneFlag) |-> $fell(goBusy))
    else $error("flag without go clear");
  a_flag_clear: assert property (swWrite.flagClear && !goBusy |=> !convDoneFlag)
    else $error("flag not cleared");
  a_sw_result: assert property (swWrite.resultWrite && !goBusy
    |=> convResultReg == $past(swWrite.resultData))
    else $error("result write lost");
  a_port_mask: assert property ((portReadData & $past(analogPinMask)) == 6'h00)
    else $error("analog pin read high");

  // Main scenarios reached
  c_done: cover property ($rose(convDoneFlag));
  c_abort: cover property (goClr && goBusy);
  c_refuse: cover property (goSet && !sampleSwitch && !goBusy);
endmodule

bind adc_conversion_sequencer adc_seq_checker chk (
  .clk(clk), .resetn(resetn), .ctrl(ctrl), .swWrite(swWrite), .goBusy(goBusy),
  .convResultReg(convResultReg), .convDoneFlag(convDoneFlag), .sampleSwitch(sampleSwitch),
  .analogPinMask(analogPinMask), .portReadData(portReadData));

// ### test/tb_top.sv
// Self-checking bench for the conversion sequencer.
// Assumes package and checker are compiled first.
`timescale 1ns/1ps

module tb_top
  import adc_seq_pkg::*;
;
  logic       clk;
  logic       resetn;
  conv_ctrl_t ctrl;
  sw_write_t  swWrite;
  logic       compIn;
  logic [5:0] portPins;
  logic [5:0] analogPinMask;
  logic       goBusy;
  logic [7:0] convResultReg;
  logic       convDoneFlag;
  logic [7:0] resultBitInvalid;
  logic       sampleSwitch;
  logic [2:0] channelMux;
  logic [7:0] dacCode;
  logic [5:0] portReadData;
  logic [7:0] level;       // Analog input as a code
  int         fail_count;
  int         check_count;
  int         n;           // Cycle counter

  adc_conversion_sequencer uut (
    .clk(clk), .resetn(resetn), .ctrl(ctrl), .swWrite(swWrite), .compIn(compIn),
    .portPins(portPins), .analogPinMask(analogPinMask), .goBusy(goBusy),
    .convResultReg(convResultReg), .convDoneFlag(convDoneFlag),
    .resultBitInvalid(resultBitInvalid), .sampleSwitch(sampleSwitch),
    .channelMux(channelMux), .dacCode(dacCode), .portReadData(portReadData));

  ////////////////////////////////////////////////////////////////
  // Ideal comparator; one clock late like a slow settle
  always @(posedge clk) compIn <= (level >= dacCode);

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare and count
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One-cycle go/done write
  task automatic go(input logic v);
    @(posedge clk);
    swWrite.goWrite <= 1'b1;
    swWrite.goValue <= v;
    @(posedge clk);
    swWrite.goWrite <= 1'b0;
  endtask

  // Wait for acquire, then a software acquisition time
  task automatic wait_acq();
    #1;
    n = 0;
    while (sampleSwitch !== 1'b1 && n < 6000) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (10) @(posedge clk);
  endtask

  // Full conversion; h is the half period in clocks
  task automatic convert(input logic [1:0] sel, input logic [7:0] lv, input int h);
    @(posedge clk);
    ctrl.convClockSelect <= sel; // select only between conversions
    level <= lv;
    wait_acq();
    go(1'b1);
    #1;
    check("busy", 8'h01, {7'h0, goBusy});
    n = 0;
    while (goBusy === 1'b1 && n < 6000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("length ok", 8'h01, {7'h0, (n >= 18 * h - 2) && (n <= 20 * h + 2)});
    if (h > 1) check("result", lv, convResultReg);
    check("flag", 8'h01, {7'h0, convDoneFlag});
    check("invalid", (h < 100) ? 8'hff : 8'h00, resultBitInvalid);
    @(posedge clk);
    swWrite.flagClear <= 1'b1;
    @(posedge clk);
    swWrite.flagClear <= 1'b0;
    #1;
    check("flag clear", 8'h00, {7'h0, convDoneFlag});
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    resetn = 1'b0;
    ctrl = '0;
    swWrite = '0;
    compIn = 1'b0;
    level = 8'h00;
    portPins = 6'h2d;
    analogPinMask = 6'h0f;
    fail_count = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    ctrl.converterOn <= 1'b1;
    ctrl.inputChannelSelect <= 3'h4;
    convert(2'h1, 8'ha5, 4);
    convert(2'h0, 8'h5a, 1);
    convert(2'h2, 8'hc3, 16);
    convert(2'h3, 8'h3c, 250); // only run meeting 1.6 us
    check("channel", 8'h04, {5'h0, channelMux});
    check("port read", 8'h20, {2'h0, portReadData});
    // four bits on 32 clocks, the rest on 2 clocks
    @(posedge clk);
    ctrl.convClockSelect <= 2'h2;
    level <= 8'h9e;
    wait_acq();
    go(1'b1);
    // Earliest switch for four bits: 2 + 4 periods of 32 clocks
    repeat (192) @(posedge clk);
    ctrl.convClockSelect <= 2'h0;
    #1;
    n = 192;
    while (goBusy === 1'b1 && n < 6000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("fast length", 8'h01, {7'h0, (n >= 193) && (n <= 215)});
    check("top bits", 8'h09, {4'h0, convResultReg[7:4]});
    check("fast invalid", 8'hff, resultBitInvalid);
    @(posedge clk);
    swWrite.flagClear <= 1'b1;
    @(posedge clk);
    swWrite.flagClear <= 1'b0;
    @(posedge clk);
    ctrl.convClockSelect <= 2'h1;
    swWrite.resultWrite <= 1'b1;
    swWrite.resultData <= 8'h96;
    @(posedge clk);
    swWrite.resultWrite <= 1'b0;
    wait_acq();
    go(1'b1);
    repeat (20) @(posedge clk);
    go(1'b0);
    #1;
    check("abort busy", 8'h00, {7'h0, goBusy});
    check("abort result", 8'h96, convResultReg);
    check("abort flag", 8'h00, {7'h0, convDoneFlag});
    go(1'b1); // refused while dead
    #1;
    check("go in dead time", 8'h00, {7'h0, goBusy});
    wait_acq();
    check("dead length", 8'h01, {7'h0, (n >= 10) && (n <= 15)});
    #1;
    check("reacquire", 8'h01, {7'h0, sampleSwitch});
    wrap_up();
  end

  // Hang guard, well past the longest expected run
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule
